// file: verilog/mit_irq_ctrl.sv
// Purpose: Merged interrupts, two time-base generators, wake-up and the
//          global enable handling of a small microcontroller.
// Assumes: Source events are one-cycle pulses from logic on core_clk;
//          dedicated_tick_source is an asynchronous pin.
// Notes:   Registers reach this block only through the core link.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "mit_consts.svh"

// Contract
// - Three merged interrupts fed only by sources
// - Merged flag sets when any source flag rises
// - Enabled merged request vectors; clears flag, global
// - Service leaves source flags; software clears them
// - Time-base flag set by divider overflow
// - Time-base vector needs global, own enable, stack
// - Control bit 7 turns both generators on
// - Bit 6 picks dedicated clock or system/4
// - Time-base 1 period 2^12 to 2^15
// - Time-base 0 period 2^8 to 2^15
// - EEPROM done flag; needs global, own, merged2
// - Low supply flag; needs global, own, merged2
// - Each timer gives P and A match flags
// - Any flag rising wakes, enables ignored
// - Software presets flag to block wake
// - Set flag holds until serviced or cleared
// - Service routine saves its own registers
// - Return with enable sets global; plain keeps
// - Avoid calls inside service routines
// - Global enable off blocks vectors, keeps flags
// - Full stack blocks acknowledge until popped
module mit_irq_ctrl (
    input  wire logic  core_clk,
    input  wire logic  rst,
    mit_core_if.dev    link,
    input  wire logic  stm_match_p,
    input  wire logic  stm_match_a,
    input  wire logic  ptm_match_p,
    input  wire logic  ptm_match_a,
    input  wire logic  eeprom_write_done,
    input  wire logic  low_supply_detect,
    input  wire logic  dedicated_tick_source
);
    // Interrupt state
    logic [`MIT_EN_W-1:0] int_en_r, int_en_nxt;
    logic [2:0]           mf_flag_r, mf_flag_nxt;
    logic [1:0]           tb_flag_r, tb_flag_nxt;
    logic [5:0]           src_flag_r, src_flag_nxt;
    logic [5:0]           src_en_r, src_en_nxt;
    logic [7:0]           tbc_r, tbc_nxt;
    logic [7:0]           rdata_r, rdata_nxt;
    logic                 wake_r, wake_nxt;
    logic                 req_r, req_nxt;
    mit_pkg::mit_vec_t    vec_r, vec_nxt;
    logic [4:0]           cand;
    logic [5:0]           src_ev;

    // Time-base state
    logic [`MIT_DIV_W-1:0] div_r, div_nxt;
    logic [1:0]            pre_r, pre_nxt;
    logic                  sync1_r, sync2_r, sync3_r;
    logic                  filt_r, filt_nxt;
    logic                  tick_step;
    logic [1:0]            tb_ovf;

    // Source order: {eeprom, low supply, ptm A, ptm P, stm A, stm P}
    assign src_ev = {eeprom_write_done, low_supply_detect, ptm_match_a, ptm_match_p,
                     stm_match_a, stm_match_p};

    // Time-base stepping: prescaler, pin filter and divider
    always_comb begin
        pre_nxt  = pre_r + 2'h1;
        filt_nxt = (sync2_r == sync3_r) ? sync3_r : filt_r;
        if (tbc_r[`MIT_TBC_CLK]) begin
            tick_step = tbc_r[`MIT_TBC_ON] & (pre_r == `MIT_PRE_LAST);
        end else begin
            tick_step = tbc_r[`MIT_TBC_ON] & filt_nxt & ~filt_r;
        end
        if (!tbc_r[`MIT_TBC_ON]) begin
            div_nxt = '0;
        end else if (tick_step) begin
            div_nxt = div_r + `MIT_DIV_W'(1);
        end else begin
            div_nxt = div_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_r   <= 2'h0;
            div_r   <= '0;
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            filt_r  <= 1'b0;
        end else begin
            pre_r   <= pre_nxt;
            div_r   <= div_nxt;
            sync1_r <= dedicated_tick_source;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r  <= filt_nxt;
        end
    end

    // One shared divider keeps both generators in phase
    mit_tick_tap #(.BASE(`MIT_TB0_BASE), .SEL_W(3)) u_tap0 (
        .tick_step (tick_step),
        .count     (div_r),
        .sel       (tbc_r[`MIT_TBC_TB0_LSB +: 3]),
        .overflow  (tb_ovf[0])
    );

    mit_tick_tap #(.BASE(`MIT_TB1_BASE), .SEL_W(2)) u_tap1 (
        .tick_step (tick_step),
        .count     (div_r),
        .sel       (tbc_r[`MIT_TBC_TB1_LSB +: 2]),
        .overflow  (tb_ovf[1])
    );

    // Flags and enables: software first, then service, then hardware sets
    always_comb begin
        int_en_nxt   = int_en_r;
        mf_flag_nxt  = mf_flag_r;
        tb_flag_nxt  = tb_flag_r;
        src_flag_nxt = src_flag_r;
        src_en_nxt   = src_en_r;
        tbc_nxt      = tbc_r;
        rdata_nxt    = rdata_r;
        if (link.reg_wr) begin
            case (link.reg_idx)
                `MIT_REG_INT_EN: int_en_nxt = link.reg_wdata[`MIT_EN_W-1:0];
                `MIT_REG_FLAGS: begin
                    mf_flag_nxt = link.reg_wdata[`MIT_FL_MF_LSB +: 3];
                    tb_flag_nxt = link.reg_wdata[`MIT_FL_TB_LSB +: 2];
                end
                `MIT_REG_SRC_STM: begin
                    src_flag_nxt[1:0] = link.reg_wdata[`MIT_SRC_FL_LSB +: 2];
                    src_en_nxt[1:0]   = link.reg_wdata[`MIT_SRC_EN_LSB +: 2];
                end
                `MIT_REG_SRC_PTM: begin
                    src_flag_nxt[3:2] = link.reg_wdata[`MIT_SRC_FL_LSB +: 2];
                    src_en_nxt[3:2]   = link.reg_wdata[`MIT_SRC_EN_LSB +: 2];
                end
                `MIT_REG_SRC_MISC: begin
                    src_flag_nxt[5:4] = link.reg_wdata[`MIT_SRC_FL_LSB +: 2];
                    src_en_nxt[5:4]   = link.reg_wdata[`MIT_SRC_EN_LSB +: 2];
                end
                `MIT_REG_TBC: tbc_nxt = link.reg_wdata & `MIT_TBC_MASK;
                default: ;
            endcase
        end
        // Service clears the vectored flag and the global enable, never the sources
        if (link.irq_ack) begin
            int_en_nxt[`MIT_EN_GLOBAL] = 1'b0;
            case (link.ack_vec)
                mit_pkg::MIT_VEC_MF0: mf_flag_nxt[0] = 1'b0;
                mit_pkg::MIT_VEC_MF1: mf_flag_nxt[1] = 1'b0;
                mit_pkg::MIT_VEC_MF2: mf_flag_nxt[2] = 1'b0;
                mit_pkg::MIT_VEC_TB0: tb_flag_nxt[0] = 1'b0;
                mit_pkg::MIT_VEC_TB1: tb_flag_nxt[1] = 1'b0;
                default: ;
            endcase
        end
        if (link.ret_irq) begin
            int_en_nxt[`MIT_EN_GLOBAL] = 1'b1;
        end
        // Hardware sets last so an event in a clearing cycle survives
        src_flag_nxt = src_flag_nxt | src_ev;
        tb_flag_nxt  = tb_flag_nxt | tb_ovf;
        for (int g = 0; g < 3; g++) begin
            if (|(src_flag_nxt[2*g +: 2] & ~src_flag_r[2*g +: 2])) begin
                mf_flag_nxt[g] = 1'b1;
            end
        end
        // Read data is captured as the read is taken
        if (link.reg_rd) begin
            case (link.reg_idx)
                `MIT_REG_INT_EN: rdata_nxt = {2'h0, int_en_r};
                `MIT_REG_FLAGS: rdata_nxt = {3'h0, tb_flag_r, mf_flag_r};
                `MIT_REG_SRC_STM: rdata_nxt = {2'h0, src_flag_r[1:0], 2'h0, src_en_r[1:0]};
                `MIT_REG_SRC_PTM: rdata_nxt = {2'h0, src_flag_r[3:2], 2'h0, src_en_r[3:2]};
                `MIT_REG_SRC_MISC: rdata_nxt = {2'h0, src_flag_r[5:4], 2'h0, src_en_r[5:4]};
                `MIT_REG_TBC: rdata_nxt = tbc_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Wake on any rising flag, whatever the enables say
    always_comb begin
        wake_nxt = |(src_flag_nxt & ~src_flag_r) | |(mf_flag_nxt & ~mf_flag_r)
                 | |(tb_flag_nxt & ~tb_flag_r);
    end

    // Candidates per vector, then the lowest index wins
    always_comb begin
        cand[mit_pkg::MIT_VEC_MF0] = mf_flag_nxt[0] & int_en_nxt[`MIT_EN_MF_LSB]
                                   & |(src_flag_nxt[1:0] & src_en_nxt[1:0]);
        cand[mit_pkg::MIT_VEC_MF1] = mf_flag_nxt[1] & int_en_nxt[`MIT_EN_MF_LSB + 1]
                                   & |(src_flag_nxt[3:2] & src_en_nxt[3:2]);
        cand[mit_pkg::MIT_VEC_TB0] = tb_flag_nxt[0] & int_en_nxt[`MIT_EN_TB_LSB];
        cand[mit_pkg::MIT_VEC_TB1] = tb_flag_nxt[1] & int_en_nxt[`MIT_EN_TB_LSB + 1];
        cand[mit_pkg::MIT_VEC_MF2] = mf_flag_nxt[2] & int_en_nxt[`MIT_EN_MF_LSB + 2]
                                   & |(src_flag_nxt[5:4] & src_en_nxt[5:4]);
        req_nxt = int_en_nxt[`MIT_EN_GLOBAL] & ~link.stack_full & (|cand);
        vec_nxt = mit_pkg::MIT_VEC_MF0;
        for (int v = 4; v >= 0; v--) begin
            if (cand[v]) begin
                vec_nxt = mit_pkg::mit_vec_t'(v[2:0]);
            end
        end
    end

    // Register every piece of interrupt state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            int_en_r   <= '0;
            mf_flag_r  <= 3'h0;
            tb_flag_r  <= 2'h0;
            src_flag_r <= 6'h00;
            src_en_r   <= 6'h00;
            tbc_r      <= `MIT_TBC_RESET;
            rdata_r    <= 8'h00;
            wake_r     <= 1'b0;
            req_r      <= 1'b0;
            vec_r      <= mit_pkg::MIT_VEC_MF0;
        end else begin
            int_en_r   <= int_en_nxt;
            mf_flag_r  <= mf_flag_nxt;
            tb_flag_r  <= tb_flag_nxt;
            src_flag_r <= src_flag_nxt;
            src_en_r   <= src_en_nxt;
            tbc_r      <= tbc_nxt;
            rdata_r    <= rdata_nxt;
            wake_r     <= wake_nxt;
            req_r      <= req_nxt;
            vec_r      <= vec_nxt;
        end
    end

    assign link.reg_rdata = rdata_r;
    assign link.irq_req   = req_r;
    assign link.irq_vec   = vec_r;
    assign link.wake      = wake_r;
endmodule // mit_irq_ctrl

// file: verilog/mit_consts.svh
// Purpose: Named offsets, field positions, reset values and counts for the
//          merged interrupt and time-base block and its core sequencer.
// Assumes: Included by bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef MIT_CONSTS_SVH
`define MIT_CONSTS_SVH

// Device register indices on the core link
`define MIT_REG_INT_EN     3'h0
`define MIT_REG_FLAGS      3'h1
`define MIT_REG_SRC_STM    3'h2
`define MIT_REG_SRC_PTM    3'h3
`define MIT_REG_SRC_MISC   3'h4
`define MIT_REG_TBC        3'h5

// Enable register fields
`define MIT_EN_GLOBAL      0
`define MIT_EN_MF_LSB      1
`define MIT_EN_TB_LSB      4
`define MIT_EN_W           6

// Flag register fields
`define MIT_FL_MF_LSB      0
`define MIT_FL_TB_LSB      3

// Source register fields: flags in 5:4, enables in 1:0
`define MIT_SRC_FL_LSB     4
`define MIT_SRC_EN_LSB     0
`define MIT_SRC_MASK       8'h33

// Time-base control fields
`define MIT_TBC_ON         7
`define MIT_TBC_CLK        6
`define MIT_TBC_TB1_LSB    4
`define MIT_TBC_TB0_LSB    0
`define MIT_TBC_RESET      8'h37
`define MIT_TBC_MASK       8'hF7

// Time-base divider
`define MIT_DIV_W          15
`define MIT_TB0_BASE       8
`define MIT_TB1_BASE       12
`define MIT_PRE_LAST       2'h3

// Core sequencer: word index = address[3:2]
`define MIT_AV_DEV_ACCESS  2'h0
`define MIT_AV_CORE_CMD    2'h1
`define MIT_AV_STATUS      2'h2
`define MIT_ACC_WRITE      16
`define MIT_ACC_DATA_LSB   8
`define MIT_CMD_RET        0
`define MIT_CMD_RETURN_FROM_INTERRUPT       1
`define MIT_CMD_SLEEP      2
`define MIT_ST_VEC_LSB     8
`define MIT_ST_LVL_LSB     11
`define MIT_ST_SLEEP       14
`define MIT_STACK_DEPTH    3'h4

`endif

// file: verilog/mit_pkg.sv
// Purpose: Shared types of the merged interrupt and time-base block.
// Assumes: Used as mit_pkg::name, never imported.
// Notes:   Vector order is also the fixed service priority, lowest first.
package mit_pkg;
    typedef enum logic [2:0] {
        MIT_VEC_MF0,
        MIT_VEC_MF1,
        MIT_VEC_TB0,
        MIT_VEC_TB1,
        MIT_VEC_MF2
    } mit_vec_t;

    typedef enum logic {
        MIT_RUN,
        MIT_SLEEP
    } mit_run_t;
endpackage

// file: verilog/mit_core_if.sv
// Purpose: Link between the interrupt block and the processor core sequencer.
// Assumes: Both ends on core_clk; no clocking block.
// Notes:   Pulses last one cycle; all signals but stack_full are driven from flip-flops.
`timescale 1ns/100ps
interface mit_core_if;
    logic             reg_wr;
    logic             reg_rd;
    logic [2:0]       reg_idx;
    logic [7:0]       reg_wdata;
    logic [7:0]       reg_rdata;
    logic             irq_req;
    mit_pkg::mit_vec_t irq_vec;
    logic             irq_ack;
    mit_pkg::mit_vec_t ack_vec;
    logic             stack_full;
    logic             ret_plain;
    logic             ret_irq;
    logic             wake;

    modport dev  (input  reg_wr, reg_rd, reg_idx, reg_wdata, irq_ack, ack_vec, stack_full, ret_plain, ret_irq,
                  output reg_rdata, irq_req, irq_vec, wake);
    modport core (output reg_wr, reg_rd, reg_idx, reg_wdata, irq_ack, ack_vec, stack_full, ret_plain, ret_irq,
                  input  reg_rdata, irq_req, irq_vec, wake);
endinterface

// file: verilog/mit_tick_tap.sv
// Purpose: Overflow tap of the shared time-base divider for one generator.
// Assumes: count advances once per tick_step.
// Notes:   Period is 2^(BASE+sel) ticks; the tap fires as the low bits wrap.
`timescale 1ns/100ps
`include "mit_consts.svh"
module mit_tick_tap #(
    parameter int BASE  = 8,
    parameter int SEL_W = 3
) (
    input  wire logic                    tick_step,
    input  wire logic [`MIT_DIV_W-1:0]   count,
    input  wire logic [SEL_W-1:0]        sel,
    output logic                         overflow
);
    logic [`MIT_DIV_W:0] span;

    // Mask of the low bits that must all be one before the wrap
    always_comb begin
        span     = (16'h0001 << (BASE + int'(sel))) - 16'h0001;
        overflow = tick_step & (&(count | ~span[`MIT_DIV_W-1:0]));
    end
endmodule // mit_tick_tap

// file: verilog/mit_core_seq.sv
// Purpose: Processor-side sequencer: takes vectors, keeps the return stack,
//          issues returns and forwards register accesses to the block.
// Assumes: Avalon-MM slave, 32-bit data, byte address, fixed wait state.
// Notes:   Every access waits exactly one cycle before it is taken.
`timescale 1ns/100ps
`include "mit_consts.svh"
module mit_core_seq (
    input  wire logic         core_clk,
    input  wire logic         rst,
    mit_core_if.core          link,
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest
);
    logic               done_r, done_nxt;
    logic [31:0]        rdata_r, rdata_nxt;
    logic               wr_r, wr_nxt, rd_r, rd_nxt, rd_p1_r;
    logic [2:0]         idx_r, idx_nxt;
    logic [7:0]         wdata_r, wdata_nxt, devdata_r, devdata_nxt;
    logic [2:0]         level_r, level_nxt;
    logic               ack_r, ack_nxt, ret_r, ret_nxt, return_from_interrupt_r, return_from_interrupt_nxt;
    mit_pkg::mit_vec_t  vec_r, vec_nxt;
    mit_pkg::mit_run_t  run_r, run_nxt;
    logic               take_wr;

    assign avs_waitrequest = (avs_read | avs_write) & ~done_r;
    assign take_wr         = avs_write & done_r;

    // Bus, link commands, stack and sleep state
    always_comb begin
        done_nxt    = (avs_read | avs_write) & ~done_r;
        rdata_nxt   = rdata_r;
        wr_nxt      = 1'b0;
        rd_nxt      = 1'b0;
        idx_nxt     = idx_r;
        wdata_nxt   = wdata_r;
        devdata_nxt = rd_p1_r ? link.reg_rdata : devdata_r;
        level_nxt   = level_r;
        ack_nxt     = 1'b0;
        ret_nxt     = 1'b0;
        return_from_interrupt_nxt    = 1'b0;
        vec_nxt     = vec_r;
        run_nxt     = run_r;
        if (avs_read && !done_r) begin
            rdata_nxt = 32'h0000_0000;
            if (avs_address[3:2] == `MIT_AV_STATUS) begin
                rdata_nxt[7:0] = devdata_r;
                rdata_nxt[`MIT_ST_VEC_LSB +: 3] = vec_r;
                rdata_nxt[`MIT_ST_LVL_LSB +: 3] = level_r;
                rdata_nxt[`MIT_ST_SLEEP] = (run_r == mit_pkg::MIT_SLEEP);
            end
        end
        if (take_wr && avs_address[3:2] == `MIT_AV_DEV_ACCESS) begin
            wr_nxt    = avs_writedata[`MIT_ACC_WRITE];
            rd_nxt    = ~avs_writedata[`MIT_ACC_WRITE];
            idx_nxt   = avs_writedata[2:0];
            wdata_nxt = avs_writedata[`MIT_ACC_DATA_LSB +: 8];
        end
        case (run_r)
            mit_pkg::MIT_RUN: begin
                if (take_wr && avs_address[3:2] == `MIT_AV_CORE_CMD) begin
                    if (avs_writedata[`MIT_CMD_SLEEP]) begin
                        run_nxt = mit_pkg::MIT_SLEEP;
                    end else if (level_r != 3'h0 && (avs_writedata[`MIT_CMD_RET] | avs_writedata[`MIT_CMD_RETURN_FROM_INTERRUPT])) begin
                        level_nxt = level_r - 3'h1;
                        return_from_interrupt_nxt  = avs_writedata[`MIT_CMD_RETURN_FROM_INTERRUPT];
                        ret_nxt   = ~avs_writedata[`MIT_CMD_RETURN_FROM_INTERRUPT];
                    end
                end else if (link.irq_req && !ack_r && level_r != `MIT_STACK_DEPTH) begin
                    ack_nxt   = 1'b1;
                    vec_nxt   = link.irq_vec;
                    level_nxt = level_r + 3'h1;
                end
            end
            mit_pkg::MIT_SLEEP: begin
                if (link.wake) begin
                    run_nxt = mit_pkg::MIT_RUN;
                end
            end
            default: run_nxt = mit_pkg::MIT_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_r    <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            wr_r      <= 1'b0;
            rd_r      <= 1'b0;
            rd_p1_r   <= 1'b0;
            idx_r     <= 3'h0;
            wdata_r   <= 8'h00;
            devdata_r <= 8'h00;
            level_r   <= 3'h0;
            ack_r     <= 1'b0;
            ret_r     <= 1'b0;
            return_from_interrupt_r    <= 1'b0;
            vec_r     <= mit_pkg::MIT_VEC_MF0;
            run_r     <= mit_pkg::MIT_RUN;
        end else begin
            done_r    <= done_nxt;
            rdata_r   <= rdata_nxt;
            wr_r      <= wr_nxt;
            rd_r      <= rd_nxt;
            rd_p1_r   <= rd_r;
            idx_r     <= idx_nxt;
            wdata_r   <= wdata_nxt;
            devdata_r <= devdata_nxt;
            level_r   <= level_nxt;
            ack_r     <= ack_nxt;
            ret_r     <= ret_nxt;
            return_from_interrupt_r    <= return_from_interrupt_nxt;
            vec_r     <= vec_nxt;
            run_r     <= run_nxt;
        end
    end

    assign avs_readdata    = rdata_r;
    assign link.reg_wr     = wr_r;
    assign link.reg_rd     = rd_r;
    assign link.reg_idx    = idx_r;
    assign link.reg_wdata  = wdata_r;
    assign link.irq_ack    = ack_r;
    assign link.ack_vec    = vec_r;
    assign link.stack_full = (level_r == `MIT_STACK_DEPTH);
    assign link.ret_plain  = ret_r;
    assign link.ret_irq    = return_from_interrupt_r;
endmodule // mit_core_seq

// file: verif/mit_link_properties.sv
// Purpose: Link properties of the merged interrupt block and its core end.
// Assumes: One clock, core_clk; rst synchronous, active high.
// Notes:   Looks only at what the two design ends drive.
`timescale 1ns/100ps
module mit_link_properties (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic              irq_req,
    input wire mit_pkg::mit_vec_t irq_vec,
    input wire logic              irq_ack,
    input wire mit_pkg::mit_vec_t ack_vec,
    input wire logic              stack_full,
    input wire logic              ret_plain,
    input wire logic              ret_irq,
    input wire logic              wake
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A service is a standing request answered by one acknowledge
    sequence s_take;
        irq_req ##1 irq_ack;
    endsequence
    a_ack_has_req: assert property (irq_ack |-> $past(irq_req) && ack_vec == $past(irq_vec))
        else $error("acknowledge without matching request");
    a_take_clears: assert property (s_take |=> !irq_req)
        else $error("request stands after service");
    a_ack_gap: assert property (irq_ack |=> !irq_ack [*2])
        else $error("acknowledge repeated too soon");
    a_ack_room: assert property (irq_ack |-> !$past(stack_full))
        else $error("acknowledge with a full stack");
    // Only an acknowledge or a register write may withdraw a request
    a_req_holds: assert property (irq_req && !irq_ack && !reg_wr && !$past(reg_wr) |=> irq_req)
        else $error("request dropped on its own");
    a_ret_one: assert property ((ret_plain || ret_irq) |-> !(ret_plain && ret_irq) ##1 !(ret_plain || ret_irq))
        else $error("return pulse malformed");
    a_acc_pulse: assert property ((reg_wr || reg_rd) |-> !(reg_wr && reg_rd) ##1 !(reg_wr || reg_rd))
        else $error("register access pulse malformed");
    a_reset_quiet: assert property ($fell(rst) |-> !irq_req && !irq_ack && !wake)
        else $error("link not quiet after reset");
endmodule // mit_link_properties

// file: verif/tb.sv
// Purpose: Drives the core end over Avalon and the source events of the block.
// Assumes: Device reached only through the core sequencer words.
// Notes:   Dedicated tick pin rises every eight clocks; both tick sources are timed.
`timescale 1ns/100ps
module tb;
    logic        core_clk, rst;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd_q;
    logic [5:0]  ev;
    logic        tick_pin;
    int          fails, comparisons, cyc, n, t_w[$];
    mit_pkg::mit_vec_t pri[3] = '{mit_pkg::MIT_VEC_MF0, mit_pkg::MIT_VEC_MF1, mit_pkg::MIT_VEC_MF2};
    mit_core_if link_if();
    mit_core_seq mit_core_seq_inst (.core_clk(core_clk), .rst(rst), .link(link_if.core), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    mit_irq_ctrl mit_irq_ctrl_inst (.core_clk(core_clk), .rst(rst), .link(link_if.dev), .stm_match_p(ev[5]),
        .stm_match_a(ev[4]), .ptm_match_p(ev[3]), .ptm_match_a(ev[2]), .eeprom_write_done(ev[1]),
        .low_supply_detect(ev[0]), .dedicated_tick_source(tick_pin));
    mit_link_properties mit_link_properties_inst (.core_clk(core_clk), .rst(rst), .reg_wr(link_if.reg_wr),
        .reg_rd(link_if.reg_rd), .irq_req(link_if.irq_req), .irq_vec(link_if.irq_vec), .irq_ack(link_if.irq_ack),
        .ack_vec(link_if.ack_vec), .stack_full(link_if.stack_full), .ret_plain(link_if.ret_plain),
        .ret_irq(link_if.ret_irq), .wake(link_if.wake));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Wake timestamps, the slow tick pin and the hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        tick_pin <= cyc[2];
        if (link_if.wake === 1'b1)
            t_w.push_back(cyc);
        if (cyc == 40000) begin
            fails++;
            $display("CHECK FAILED at %0t: timeout", $time);
            final_report();
        end
    end
    task automatic final_report();
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Held until waitrequest is seen low at a rising edge
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic dev_wr(input logic [2:0] i, input logic [7:0] d);
        av(4'h0, 1'b1, {15'h0, 1'b1, d, 5'h0, i});
    endtask
    // Device read lands in the status word a fixed few cycles later
    task automatic dev_rd(input logic [2:0] i, input logic [7:0] e);
        av(4'h0, 1'b1, {29'h0, i});
        repeat (4) @(posedge core_clk);
        av(4'h8, 1'b0, 32'h0);
        chk(rd_q[7:0], e);
    endtask
    task automatic status(input mit_pkg::mit_vec_t v, input logic [2:0] l);
        repeat (4) @(posedge core_clk);
        av(4'h8, 1'b0, 32'h0);
        chk(rd_q[13:8], {l, v});
    endtask
    task automatic cmd(input logic [2:0] c);
        av(4'h4, 1'b1, {29'h0, c});
    endtask
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge core_clk);
        ev <= 6'h00;
        @(posedge core_clk);
    endtask
    initial begin
        rst = 1'b1;
        ev = 6'h00;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        dev_rd(3'h5, 8'h37);
        dev_wr(3'h5, 8'h7F);
        dev_rd(3'h5, 8'h77);
        // Merged service keeps the source flag
        dev_wr(3'h2, 8'h01);
        dev_wr(3'h0, 8'h03);
        pulse(6'h20);
        status(mit_pkg::MIT_VEC_MF0, 3'h1);
        dev_rd(3'h0, 8'h02);
        dev_rd(3'h1, 8'h00);
        dev_rd(3'h2, 8'h11);
        cmd(3'h2);
        dev_rd(3'h0, 8'h03);
        // Global enable off records without vectoring
        dev_wr(3'h2, 8'h03);
        dev_wr(3'h0, 8'h02);
        pulse(6'h10);
        dev_rd(3'h1, 8'h01);
        status(mit_pkg::MIT_VEC_MF0, 3'h0);
        dev_wr(3'h0, 8'h03);
        status(mit_pkg::MIT_VEC_MF0, 3'h1);
        cmd(3'h1);
        dev_rd(3'h0, 8'h02);
        // Simultaneous sources are taken one after another
        dev_wr(3'h2, 8'h01);
        dev_wr(3'h3, 8'h01);
        dev_wr(3'h4, 8'h03);
        pulse(6'h2B);
        dev_wr(3'h0, 8'h0F);
        foreach (pri[k]) begin
            status(pri[k], 3'h1);
            cmd(3'h2);
        end
        // Nesting until the stack is full
        dev_wr(3'h0, 8'h02);
        repeat (5) begin
            dev_wr(3'h2, 8'h01);
            pulse(6'h20);
            dev_wr(3'h0, 8'h03);
        end
        status(mit_pkg::MIT_VEC_MF0, 3'h4);
        dev_rd(3'h1, 8'h01);
        cmd(3'h1);
        dev_rd(3'h1, 8'h00);
        // Asleep: a flag already set cannot wake, a fresh one does
        cmd(3'h4);
        pulse(6'h20);
        status(mit_pkg::MIT_VEC_MF0, 3'h4);
        chk(rd_q[14], 1'b1);
        pulse(6'h10);
        status(mit_pkg::MIT_VEC_MF0, 3'h4);
        chk(rd_q[14], 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Time bases on system/4, shortest periods, enables off
        dev_wr(3'h5, 8'h40);
        n = t_w.size();
        repeat (1500) @(posedge core_clk);
        chk(t_w.size(), n);
        dev_wr(3'h5, 8'hC0);
        while (t_w.size() < n + 1) @(posedge core_clk);
        dev_wr(3'h1, 8'h00);
        while (t_w.size() < n + 3) @(posedge core_clk);
        chk(t_w[n + 1] - t_w[n], 1024);
        chk(t_w[n + 2] - t_w[n], 15360);
        dev_wr(3'h0, 8'h11);
        status(mit_pkg::MIT_VEC_TB0, 3'h1);
        dev_rd(3'h1, 8'h10);
        // Dedicated pin: one tick per rising edge, eight clocks apart
        dev_wr(3'h5, 8'h80);
        n = t_w.size();
        while (t_w.size() < n + 1) @(posedge core_clk);
        dev_wr(3'h1, 8'h00);
        while (t_w.size() < n + 2) @(posedge core_clk);
        chk(t_w[n + 1] - t_w[n], 2048);
        final_report();
    end
endmodule // tb
